/* ccc_chip_config.sv */
// Chip configuration register with its DMA routing, pin sharing, error
// routing, bus ownership arbitration and external interrupt sensing.
// Assumes all inputs synchronous to clk; pins are split into in/out/oe.
`timescale 1ns/1ps
// Behaviour
// - bit31 routes DMA ch2 to serial port 1
// - bit30 routes DMA ch1 to serial port 0
// - bit29 selects io port 2 or A31..A24
// - bit28 selects io port 1 or bus/DMA pins
// - bit27 sends watchdog to reset or NMI
// - bit26 enables bus timeout detection
// - bad write raises NMI and flag bit16
// - bits25:24 set external master request level
// - highest pending level wins; snoop levels snoop
// - DMA competes at snoop or general only
// - release bus to requesting external master
// - clear field clears line n, reads zero
// - two-bit sense per interrupt line
// - forward request when sense condition met
// - writing edge code drops pending edge
module ccc_chip_config import ccc_pkg::*; (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [3:0] avsAddress,
   input wire logic avsRead,
   input wire logic avsWrite,
   input wire logic [31:0] avsWriteData,
   input wire logic [3:0] avsByteEnable,
   output logic [31:0] avsReadData,
   output logic avsWaitRequest,
   output logic irqOut,
   input wire logic dmaReqPin1,
   output logic dmaAckPin1,
   input wire logic sio0DmaReq,
   input wire logic sio1DmaReq,
   output logic sio0DmaAck,
   output logic sio1DmaAck,
   output logic [3:1] dmaChReq,
   input wire logic [3:1] dmaChAck,
   input wire logic [7:0] io2Out,
   input wire logic [7:0] io2Oe,
   output logic [7:0] io2In,
   input wire logic [7:0] addrHigh,
   input wire logic addrOe,
   input wire logic [7:0] p2PinIn,
   output logic [7:0] p2PinOut,
   output logic [7:0] p2PinOe,
   input wire logic [7:0] io1Out,
   input wire logic [7:0] io1Oe,
   output logic [7:0] io1In,
   input wire logic [7:0] p1PinIn,
   output logic [7:0] p1PinOut,
   output logic [7:0] p1PinOe,
   input wire logic dmaBusReq,
   input wire logic dmaBusSnoop,
   output logic dmaBusGnt,
   output logic snoopEnable,
   input wire logic wdtIrq,
   input wire logic busTimeout,
   input wire logic procWrStrobe,
   input wire logic [31:0] procWrAddr,
   input wire logic procWrNoReg,
   input wire logic busErrorInN,
   output logic nmiOut,
   output logic chipResetOut,
   output logic timeoutDetectEn,
   input wire logic [7:0] extIrqPin,
   output logic [7:0] extIrqReq
);

   // Level of the DMA engine: snoop or general, never high priority
   function automatic logic [1:0] dmaLevel(input logic snoop);
      dmaLevel = snoop ? CCC_PRI_SRQ : CCC_PRI_GRQ;
   endfunction : dmaLevel

   function automatic logic isSnoop(input logic [1:0] lvl);
      isSnoop = (lvl == CCC_PRI_HPS) || (lvl == CCC_PRI_SRQ);
   endfunction : isSnoop

   function automatic logic isEdge(input logic [1:0] sns);
      isEdge = (sns == CCC_SNS_RISE) || (sns == CCC_SNS_FALL);
   endfunction : isEdge

   logic [31:0] cfg_r;
   logic [31:0] cfg_nxt;
   logic wrErr_r;
   logic [CCC_EV_W-1:0] sts_r;
   logic [CCC_EV_W-1:0] sts_nxt;
   logic [CCC_EV_W-1:0] msk_r;
   logic waitReq_r;
   logic [31:0] rdData_r;
   logic irq_r;
   logic [7:0] prevIrq_r;
   logic [7:0] pend_r;
   logic [7:0] pend_nxt;
   logic [7:0] irqReq_r;
   logic [7:0] irqReq_nxt;
   ccc_bus_t bus_r;
   ccc_bus_t bus_nxt;
   logic nmi_r;
   logic rst_r;
   logic [3:1] dmaChReq_r;
   logic dmaAck1_r;
   logic sio0Ack_r;
   logic sio1Ack_r;
   logic [7:0] p2Out_r;
   logic [7:0] p2Oe_r;
   logic [7:0] io2In_r;
   logic [7:0] p1Out_r;
   logic [7:0] p1Oe_r;
   logic [7:0] io1In_r;
   logic dmaGnt_r;
   logic snoop_r;

   // Bus slave decode
   wire bus_request_in = avsRead | avsWrite;
   wire load = bus_request_in & waitReq_r;
   wire accept = bus_request_in & ~waitReq_r;
   wire [3:0] wordAddr = {avsAddress[3:2], 2'b00};
   wire hitCfg = (wordAddr == CCC_OFF_CFG);
   wire hitSts = (wordAddr == CCC_OFF_STS);
   wire hitMsk = (wordAddr == CCC_OFF_MSK);
   wire unmapped = ~(hitCfg | hitSts | hitMsk);
   wire cfgWr = accept & avsWrite & hitCfg;
   wire mskWr = accept & avsWrite & hitMsk & avsByteEnable[0];
   wire [31:0] byteMask = {{8{avsByteEnable[3]}}, {8{avsByteEnable[2]}},
                           {8{avsByteEnable[1]}}, {8{avsByteEnable[0]}}};

   wire [31:0] wrMask = byteMask & CCC_CFG_WMASK;
   wire [31:0] cfgView = cfg_r | ({31'h0, wrErr_r} << CCC_B_WRERR);
   wire [31:0] readMux = hitCfg ? cfgView :
                         hitSts ? {{(32-CCC_EV_W){1'b0}}, sts_r} :
                         hitMsk ? {{(32-CCC_EV_W){1'b0}}, msk_r} : 32'h0000_0000;

   // Named configuration fields
   wire ser1Dma = cfg_r[CCC_B_SER1DMA];
   wire ser0Dma = cfg_r[CCC_B_SER0DMA];
   wire p2Sel = cfg_r[CCC_B_P2];
   wire p1Sel = cfg_r[CCC_B_P1];
   wire wdtToReset = cfg_r[CCC_B_WDR];
   wire tmoEn = cfg_r[CCC_B_TMOEN];
   wire [1:0] extLvl = cfg_r[CCC_B_PRI +: 2];

   always_comb begin
      cfg_nxt = cfg_r;
      if (cfgWr) begin
         cfg_nxt = (cfg_r & ~wrMask) | (avsWriteData & wrMask);
      end
   end

   // write to missing register, hole or bus error
   wire holeHit = (procWrAddr[31:12] == CCC_HOLE_ADDR);
   wire procBadWr = procWrStrobe & (procWrNoReg | holeHit | ~busErrorInN);
   wire evWrErr = procBadWr | (accept & avsWrite & unmapped);
   wire evTmo = busTimeout & tmoEn;
   wire [CCC_EV_W-1:0] evVec = {evTmo, wdtIrq, evWrErr};
   // Clear only what the read returned, so a late event is not lost
   wire [CCC_EV_W-1:0] stsClr = (accept & avsRead & hitSts) ?
                                rdData_r[CCC_EV_W-1:0] : CCC_EV_RST;
   assign sts_nxt = evVec | (sts_r & ~stsClr);
   // Flag is write-one-to-clear; a new error wins
   wire wrErrClr = cfgWr & avsByteEnable[2] & avsWriteData[CCC_B_WRERR];
   wire wrErr_nxt = evWrErr | (wrErr_r & ~wrErrClr);

   // External interrupt lines
   wire clrWr = cfgWr & avsByteEnable[2];
   wire [2:0] clrLine = avsWriteData[CCC_B_CLR +: 3];
   always_comb begin
      pend_nxt = pend_r;
      irqReq_nxt = irqReq_r;
      for (int n = 0; n < 8; n++) begin
         logic [1:0] sns;
         logic [1:0] newSns;
         logic hit;
         logic drop;
         sns = cfg_r[n*CCC_W_SNS +: 2];
         newSns = avsWriteData[n*CCC_W_SNS +: 2];
         hit = ((sns == CCC_SNS_RISE) & extIrqPin[n] & ~prevIrq_r[n]) |
               ((sns == CCC_SNS_FALL) & ~extIrqPin[n] & prevIrq_r[n]);
         // clear code n drops line n
         drop = clrWr & (clrLine == n[2:0]);
         // new edge code drops pending edge
         if (cfgWr && avsByteEnable[n / 4] && isEdge(newSns)) begin
            drop = 1'b1;
         end
         pend_nxt[n] = hit | (pend_r[n] & ~drop);
         if (isEdge(sns)) begin
            irqReq_nxt[n] = pend_nxt[n];
         end else if (sns == CCC_SNS_HIGH) begin
            irqReq_nxt[n] = extIrqPin[n];
         end else begin
            irqReq_nxt[n] = ~extIrqPin[n];
         end
      end
   end

   // Bus ownership; shared pins only carry bus signals in function mode
   wire extPend = ~p1Sel & ~p1PinIn[1];
   wire [1:0] dmaLvl = dmaLevel(dmaBusSnoop);
   always_comb begin
      bus_nxt = bus_r;
      unique case (bus_r)
         BUS_CPU: begin
            // highest level wins, external on a tie
            if (extPend && (!dmaBusReq || extLvl >= dmaLvl)) begin
               bus_nxt = BUS_EXT;
            end else if (dmaBusReq) begin
               bus_nxt = BUS_DMA;
            end
         end
         // held until the external master lets go
         BUS_EXT: begin
            if (!extPend) begin
               bus_nxt = BUS_CPU;
            end
         end
         BUS_DMA: begin
            if (!dmaBusReq) begin
               bus_nxt = BUS_CPU;
            end
         end
      endcase
   end

   // snoop runs only for the snoop levels
   wire snoop_nxt = ((bus_nxt == BUS_EXT) & isSnoop(extLvl)) |
                    ((bus_nxt == BUS_DMA) & isSnoop(dmaLvl));
   // release asked when DMA outranks the holder
   wire relReq = (bus_r == BUS_EXT) & dmaBusReq & (dmaLvl > extLvl);

   // function side of port 1 pins, bit 7 down to 0
   wire [7:0] p1FnOut = {2'b00, dmaChAck[3], dmaChAck[2] & ~ser1Dma, ~relReq,
                         bus_nxt == BUS_EXT, 1'b0, bus_nxt != BUS_EXT};
   wire [7:0] p1Out_nxt = p1Sel ? io1Out : p1FnOut;
   wire [7:0] p1Oe_nxt = p1Sel ? io1Oe : CCC_P1_FN_OE;
   // port 2 pins carry A31..A24 in order
   wire [7:0] p2Out_nxt = p2Sel ? io2Out : addrHigh;
   wire [7:0] p2Oe_nxt = p2Sel ? io2Oe : {8{addrOe}};

   // channel 2 from serial port 1 or shared pin
   wire ch2Req = ser1Dma ? sio1DmaReq : (~p1Sel & p1PinIn[6]);
   // channel 1 from serial port 0 or pin
   wire ch1Req = ser0Dma ? sio0DmaReq : dmaReqPin1;
   wire ch3Req = ~p1Sel & p1PinIn[7];

   wire rst_nxt = wdtIrq & wdtToReset;
   // NMI for bad writes; timeouts share it
   wire nmi_nxt = evWrErr | (wdtIrq & ~wdtToReset) | evTmo;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cfg_r <= CCC_CFG_RST;
         wrErr_r <= 1'b0;
         sts_r <= CCC_EV_RST;
         msk_r <= CCC_EV_RST;
         irq_r <= 1'b0;
         waitReq_r <= 1'b1;
         rdData_r <= 32'h0000_0000;
      end else begin
         cfg_r <= cfg_nxt;
         wrErr_r <= wrErr_nxt;
         sts_r <= sts_nxt;
         if (mskWr) begin
            msk_r <= avsWriteData[CCC_EV_W-1:0];
         end
         irq_r <= |(sts_r & msk_r);
         waitReq_r <= ~load;
         if (load) begin
            rdData_r <= readMux;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         prevIrq_r <= 8'h00;
         pend_r <= 8'h00;
         irqReq_r <= 8'h00;
         bus_r <= BUS_CPU;
         snoop_r <= 1'b0;
         dmaGnt_r <= 1'b0;
         nmi_r <= 1'b0;
         rst_r <= 1'b0;
      end else begin
         prevIrq_r <= extIrqPin;
         pend_r <= pend_nxt;
         irqReq_r <= irqReq_nxt;
         bus_r <= bus_nxt;
         snoop_r <= snoop_nxt;
         dmaGnt_r <= (bus_nxt == BUS_DMA);
         nmi_r <= nmi_nxt;
         rst_r <= rst_nxt;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         dmaChReq_r <= 3'h0;
         dmaAck1_r <= 1'b0;
         sio0Ack_r <= 1'b0;
         sio1Ack_r <= 1'b0;
         p2Out_r <= 8'h00;
         p2Oe_r <= 8'h00;
         io2In_r <= 8'h00;
         p1Out_r <= 8'h00;
         p1Oe_r <= 8'h00;
         io1In_r <= 8'h00;
      end else begin
         dmaChReq_r <= {ch3Req, ch2Req, ch1Req};
         dmaAck1_r <= dmaChAck[1] & ~ser0Dma;
         sio0Ack_r <= dmaChAck[1] & ser0Dma;
         sio1Ack_r <= dmaChAck[2] & ser1Dma;
         p2Out_r <= p2Out_nxt;
         p2Oe_r <= p2Oe_nxt;
         io2In_r <= p2Sel ? p2PinIn : 8'h00;
         p1Out_r <= p1Out_nxt;
         p1Oe_r <= p1Oe_nxt;
         io1In_r <= p1Sel ? p1PinIn : 8'h00;
      end
   end

   assign avsReadData = rdData_r;
   assign avsWaitRequest = waitReq_r;
   assign irqOut = irq_r;
   assign dmaAckPin1 = dmaAck1_r;
   assign sio0DmaAck = sio0Ack_r;
   assign sio1DmaAck = sio1Ack_r;
   assign dmaChReq = dmaChReq_r;
   assign io2In = io2In_r;
   assign p2PinOut = p2Out_r;
   assign p2PinOe = p2Oe_r;
   assign io1In = io1In_r;
   assign p1PinOut = p1Out_r;
   assign p1PinOe = p1Oe_r;
   assign dmaBusGnt = dmaGnt_r;
   assign snoopEnable = snoop_r;
   assign nmiOut = nmi_r;
   assign chipResetOut = rst_r;
   assign timeoutDetectEn = cfg_r[CCC_B_TMOEN];
   assign extIrqReq = irqReq_r;

endmodule : ccc_chip_config

/* ccc_chip_config_assertions.sv */
// Port assertions for the chip configuration block.
// Mirrors the config top byte from accepted Avalon writes.
`timescale 1ns/1ps
module ccc_chip_config_assertions import ccc_pkg::*; (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [3:0] avsAddress,
   input wire logic avsRead,
   input wire logic avsWrite,
   input wire logic [31:0] avsWriteData,
   input wire logic [3:0] avsByteEnable,
   input wire logic avsWaitRequest,
   input wire logic dmaReqPin1,
   input wire logic dmaAckPin1,
   input wire logic sio0DmaReq,
   input wire logic sio0DmaAck,
   input wire logic [3:1] dmaChReq,
   input wire logic [3:1] dmaChAck,
   input wire logic [7:0] io2Out,
   input wire logic [7:0] addrHigh,
   input wire logic [7:0] p2PinOut,
   input wire logic [7:0] p1PinOe,
   input wire logic wdtIrq,
   input wire logic procWrStrobe,
   input wire logic procWrNoReg,
   input wire logic [31:0] procWrAddr,
   input wire logic busErrorInN,
   input wire logic nmiOut,
   input wire logic chipResetOut,
   input wire logic timeoutDetectEn
);
   logic [7:0] cfgHi_r;
   wire cfgWr = avsWrite && !avsWaitRequest && avsAddress[3:2] == 2'h0 && avsByteEnable[3];
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) cfgHi_r <= 8'h00;
      else if (cfgWr) cfgHi_r <= avsWriteData[31:24];
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   a_wait_one_cycle: assert property ( // bus
      (avsRead || avsWrite) && avsWaitRequest |=> !avsWaitRequest)
      else $error("waitrequest not low one cycle after request");
   a_ch1_req_route: assert property (
      $past(rstn) |-> dmaChReq[1] == $past(cfgHi_r[6] ? sio0DmaReq : dmaReqPin1))
      else $error("channel 1 request from wrong source");
   a_ch1_ack_route: assert property (
      $past(rstn) |-> sio0DmaAck == $past(cfgHi_r[6] & dmaChAck[1])
         && dmaAckPin1 == $past(!cfgHi_r[6] & dmaChAck[1]))
      else $error("channel 1 acknowledge to wrong side");
   a_port2_pin_mux: assert property (
      $past(rstn) |-> p2PinOut == $past(cfgHi_r[5] ? io2Out : addrHigh))
      else $error("port 2 pins show wrong source");
   a_port1_fn_oe: assert property (
      $past(rstn) && !$past(cfgHi_r[4]) |-> p1PinOe == CCC_P1_FN_OE)
      else $error("port 1 function enables wrong");
   a_timeout_enable: assert property (
      timeoutDetectEn == cfgHi_r[2])
      else $error("timeout enable does not follow config");
   a_wdt_reset_route: assert property (
      wdtIrq |=> chipResetOut == $past(cfgHi_r[3]))
      else $error("watchdog reset routing wrong");
   a_wdt_nmi_route: assert property (
      wdtIrq && !cfgHi_r[3] |=> nmiOut)
      else $error("watchdog did not raise nmi");
   a_bad_write_nmi: assert property (
      procWrStrobe && procWrNoReg |=> nmiOut)
      else $error("bad write did not raise nmi");
   a_bus_err_nmi: assert property (
      procWrStrobe && !busErrorInN |=> nmiOut)
      else $error("bus error write did not raise nmi");
   a_hole_write_nmi: assert property (
      procWrStrobe && procWrAddr[31:12] == CCC_HOLE_ADDR |=> nmiOut)
      else $error("write to address hole did not raise nmi");
endmodule : ccc_chip_config_assertions

bind ccc_chip_config ccc_chip_config_assertions u_chk (.*);

/* ccc_dma_model.sv */
// Far-side DMA controller model: acknowledges channel requests.
// Answers one cycle late, or two when slow is high.
`timescale 1ns/1ps
module ccc_dma_model (
   input wire logic clk,
   input wire logic rstn,
   input wire logic slow,
   input wire logic [3:1] dmaChReq,
   output logic [3:1] dmaChAck
);
   logic [3:1] reqDly_r;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         reqDly_r <= 3'h0;
         dmaChAck <= 3'h0;
      end else begin
         reqDly_r <= dmaChReq;
         dmaChAck <= slow ? reqDly_r & dmaChReq : dmaChReq;
      end
   end
endmodule : ccc_dma_model

/* ccc_pkg.sv */
// Constants for the chip configuration control block.
// Assumes one 125 MHz clock and byte addresses on a small Avalon-MM window.
package ccc_pkg;
   // Register window, byte addresses
   localparam logic [3:0] CCC_OFF_CFG = 4'h0;
   localparam logic [3:0] CCC_OFF_STS = 4'h4;
   localparam logic [3:0] CCC_OFF_MSK = 4'h8;
   // Configuration fields
   localparam int CCC_B_SER1DMA = 31;
   localparam int CCC_B_SER0DMA = 30;
   localparam int CCC_B_P2 = 29;
   localparam int CCC_B_P1 = 28;
   localparam int CCC_B_WDR = 27;
   localparam int CCC_B_TMOEN = 26;
   localparam int CCC_B_PRI = 24;
   localparam int CCC_B_CLR = 21;
   localparam int CCC_B_WRERR = 16;
   localparam int CCC_W_SNS = 2;
   localparam logic [31:0] CCC_CFG_RST = 32'h0000_0000;
   localparam logic [31:0] CCC_CFG_WMASK = 32'hFF00_FFFF;
   // Hole in the peripheral space, upper 20 address bits
   localparam logic [19:0] CCC_HOLE_ADDR = 20'hFFFFD;
   // Bus request levels
   localparam logic [1:0] CCC_PRI_HPS = 2'h3;
   localparam logic [1:0] CCC_PRI_HPG = 2'h2;
   localparam logic [1:0] CCC_PRI_SRQ = 2'h1;
   localparam logic [1:0] CCC_PRI_GRQ = 2'h0;
   // Interrupt sense codes
   localparam logic [1:0] CCC_SNS_RISE = 2'h3;
   localparam logic [1:0] CCC_SNS_FALL = 2'h2;
   localparam logic [1:0] CCC_SNS_HIGH = 2'h1;
   localparam logic [1:0] CCC_SNS_LOW = 2'h0;
   // Event status bits
   localparam int CCC_EV_WRERR = 0;
   localparam int CCC_EV_WDT = 1;
   localparam int CCC_EV_TMO = 2;
   localparam int CCC_EV_W = 3;
   localparam logic [CCC_EV_W-1:0] CCC_EV_RST = 3'h0;
   // Port 1 shared pins: which carry device outputs in function mode
   localparam logic [7:0] CCC_P1_FN_OE = 8'h3D;
   typedef enum logic [1:0] {BUS_CPU, BUS_EXT, BUS_DMA} ccc_bus_t;
endpackage : ccc_pkg

/* testbench.sv */
// Self-checking bench for the chip configuration block.
// Drives Avalon, pins and events; DMA side is the far-side model.
`timescale 1ns/1ps
module testbench import ccc_pkg::*;;
   logic clk, rstn, avsRead, avsWrite, avsWaitRequest, irqOut, dmaReqPin1, dmaAckPin1;
   logic sio0DmaReq, sio1DmaReq, sio0DmaAck, sio1DmaAck, addrOe, dmaBusReq, dmaBusSnoop;
   logic dmaBusGnt, snoopEnable, wdtIrq, busTimeout, procWrStrobe, procWrNoReg, busErrorInN;
   logic nmiOut, chipResetOut, timeoutDetectEn, slowAck, hit, hitRst;
   logic [3:0] avsAddress, avsByteEnable;
   logic [31:0] avsWriteData, avsReadData, procWrAddr, q;
   logic [3:1] dmaChReq, dmaChAck;
   logic [7:0] io2Out, io2Oe, io2In, addrHigh, p2PinIn, p2PinOut, p2PinOe, io1Out, io1Oe;
   logic [7:0] io1In, p1PinIn, p1PinOut, p1PinOe, extIrqPin, extIrqReq;
   int badCount, nCompared;
   ccc_chip_config DUT (.*);
   ccc_dma_model u_dma (.clk, .rstn, .slow(slowAck), .dmaChReq, .dmaChAck);
   initial begin
      clk = 0;
      forever #4 clk = ~clk;
   end
   task summarize;
      $display("compared %0d mismatches %0d", nCompared, badCount);
      if (badCount == 0 && nCompared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : summarize
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      nCompared++;
      if (g !== e) begin
         badCount++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   // One Avalon access; holds until waitrequest is sampled low
   task acc(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
      int i;
      @(posedge clk);
      avsAddress <= a;
      avsWriteData <= d;
      avsByteEnable <= be;
      avsWrite <= w;
      avsRead <= !w;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (avsWaitRequest === 1'b0) break;
      end
      q = avsReadData;
      avsWrite <= 1'b0;
      avsRead <= 1'b0;
      if (i == 20) begin
         badCount++;
         summarize();
      end
   endtask : acc
   // Pulse one event input (0 watchdog, 1 timeout, else write strobe), watch both outputs
   task pls(input int sel);
      case (sel)
         0: wdtIrq <= 1'b1;
         1: busTimeout <= 1'b1;
         default: procWrStrobe <= 1'b1;
      endcase
      @(posedge clk);
      {wdtIrq, busTimeout, procWrStrobe} <= 3'b000;
      hit = 1'b0;
      hitRst = 1'b0;
      repeat (4) begin
         @(posedge clk);
         hit |= nmiOut;
         hitRst |= chipResetOut;
      end
   endtask : pls
   task t_reset;
      acc(0, CCC_OFF_CFG, 32'h0, 4'hF);
      chk("config", 32'h0, q);
      chk("p1 oe", CCC_P1_FN_OE, p1PinOe);
      chk("p2 pins", addrHigh, p2PinOut);
      chk("irq req", 8'hFF, extIrqReq);
   endtask : t_reset
   task t_route;
      acc(1, CCC_OFF_CFG, 32'hC000_0000, 4'h8);
      {sio0DmaReq, sio1DmaReq, slowAck} <= 3'b111;
      cyc(5);
      chk("ch req", 3'h3, dmaChReq[2:1]);
      chk("acks", 3'h6, {sio0DmaAck, sio1DmaAck, dmaAckPin1});
      acc(1, CCC_OFF_CFG, 32'h0, 4'h8);
      {sio0DmaReq, sio1DmaReq, dmaReqPin1, p1PinIn} <= {3'b001, 8'h42};
      cyc(5);
      chk("pin req", 3'h3, dmaChReq[2:1]);
      chk("pin acks", 3'h1, {sio0DmaAck, sio1DmaAck, dmaAckPin1});
      {dmaReqPin1, p1PinIn} <= {1'b0, 8'h02};
   endtask : t_route
   task t_pins;
      acc(1, CCC_OFF_CFG, 32'h3000_0000, 4'h8);
      {io2Out, p2PinIn} <= 16'h5AA5;
      cyc(4);
      chk("p2 out", 8'h5A, p2PinOut);
      chk("p2 in", 8'hA5, io2In);
      chk("p1 in", p1PinIn, io1In);
      addrOe <= 1'b1;
      acc(1, CCC_OFF_CFG, 32'h0, 4'h8);
      cyc(3);
      chk("addr pins", addrHigh, p2PinOut);
      chk("addr oe", 8'hFF, p2PinOe);
      pls(1);
      chk("tmo disabled", 1'b0, hit);
   endtask : t_pins
   task t_err;
      acc(1, CCC_OFF_CFG, 32'h0C00_0000, 4'h8);
      acc(1, CCC_OFF_MSK, 32'h7, 4'h1);
      cyc(2);
      chk("tmo en", 1'b1, timeoutDetectEn);
      pls(0);
      chk("wdt reset", 1'b1, hitRst);
      chk("wdt no nmi", 1'b0, hit);
      acc(1, CCC_OFF_CFG, 32'h0400_0000, 4'h8);
      pls(0);
      chk("wdt nmi", 1'b1, hit);
      chk("wdt no reset", 1'b0, hitRst);
      pls(1);
      chk("tmo nmi", 1'b1, hit);
      procWrNoReg <= 1'b1;
      pls(2);
      chk("noreg nmi", 1'b1, hit);
      {procWrNoReg, busErrorInN} <= 2'b00;
      pls(2);
      chk("bus_error_in nmi", 1'b1, hit);
      {busErrorInN, procWrAddr} <= {1'b1, 32'hFFFF_D010};
      pls(2);
      chk("hole nmi", 1'b1, hit);
      procWrAddr <= 32'hFFFF_E000;
      pls(2);
      chk("good write", 1'b0, hit);
      acc(0, CCC_OFF_CFG, 32'h0, 4'hF);
      chk("flag", 32'h0401_0000, q);
      chk("irq on", 1'b1, irqOut);
      acc(0, CCC_OFF_STS, 32'h0, 4'hF);
      chk("status", 32'h7, q);
      cyc(2);
      chk("irq off", 1'b0, irqOut);
      acc(1, CCC_OFF_MSK, 32'h0, 4'h1);
      acc(1, 4'hC, 32'hFFFF_FFFF, 4'hF);
      acc(0, 4'hC, 32'h0, 4'hF);
      chk("unmapped", 32'h0, q);
      cyc(2);
      chk("masked", 1'b0, irqOut);
      acc(0, CCC_OFF_STS, 32'h0, 4'hF);
      chk("bad bus write", 32'h1, q);
   endtask : t_err
   task t_irq;
      extIrqPin <= 8'h10;
      acc(1, CCC_OFF_CFG, 32'h0000_02C1, 4'h3);
      extIrqPin <= 8'h09;
      cyc(3);
      chk("senses", 5'h1F, extIrqReq[4:0]);
      extIrqPin <= 8'h00;
      cyc(3);
      chk("pending", 5'h1E, extIrqReq[4:0]);
      acc(1, CCC_OFF_CFG, 32'h007F_0000, 4'h4);
      cyc(2);
      chk("clear 3", 5'h16, extIrqReq[4:0]);
      acc(0, CCC_OFF_CFG, 32'h0, 4'hF);
      chk("cfg 23:16", 8'h00, q[23:16]);
      acc(1, CCC_OFF_CFG, 32'h0000_02C1, 4'h3);
      cyc(2);
      chk("rewrite", 5'h06, extIrqReq[4:0]);
   endtask : t_irq
   task t_arb;
      acc(1, CCC_OFF_CFG, 32'h0100_0000, 4'h8);
      {p1PinIn, dmaBusSnoop} <= {8'h00, 1'b1};
      cyc(3);
      chk("ext grant", 2'h2, {snoopEnable, p1PinOut[0]});
      dmaBusReq <= 1'b1;
      cyc(3);
      chk("dma waits", 1'b0, dmaBusGnt);
      p1PinIn <= 8'h02;
      cyc(4);
      chk("dma grant", 2'h3, {dmaBusGnt, snoopEnable});
   endtask : t_arb
   initial begin
      {rstn, avsRead, avsWrite, dmaReqPin1, sio0DmaReq, sio1DmaReq, slowAck} = 0;
      {addrOe, dmaBusReq, dmaBusSnoop, wdtIrq, busTimeout, procWrStrobe, procWrNoReg} = 0;
      {avsAddress, avsByteEnable, avsWriteData, procWrAddr} = 0;
      {io2Out, io2Oe, io1Out, io1Oe, p2PinIn, extIrqPin} = 0;
      {busErrorInN, addrHigh, p1PinIn} = {1'b1, 8'hC3, 8'h02};
      {badCount, nCompared} = 0;
      cyc(20);
      rstn <= 1'b1;
      t_reset();
      t_route();
      t_pins();
      t_err();
      t_irq();
      t_arb();
      summarize();
   end
endmodule : testbench
